//--- verilog/eeboard_defines.svh
/*
  Constants for the non-volatile memory board control logic: strap layout,
  address fields, and timing counts at a 50 MHz clock.
  Assumes the includer works in whole clock cycles of 20 ns.
*/
`ifndef EEBOARD_DEFINES_SVH
`define EEBOARD_DEFINES_SVH

`define CLK_PERIOD_NS 20
// Page field of the 20-bit memory address
`define PAGE_MSB 19
`define PAGE_LSB 16
// I/O address fields
`define IO_FUNC_BIT 0
`define IO_MATCH_MSB 7
`define IO_MATCH_LSB 1
// Array window inside the page: 16K bytes
`define ARRAY_TOP_MSB 15
`define ARRAY_TOP_LSB 14
// Write pulse widths
`define WP_FAST_MS 10
`define WP_SLOW_MS 50
`define WP_FAST_CYCLES ((`WP_FAST_MS * 1000000) / `CLK_PERIOD_NS)
`define WP_SLOW_CYCLES ((`WP_SLOW_MS * 1000000) / `CLK_PERIOD_NS)
// Acknowledge delay covering the slowest device
`define ACK_DELAY_NS 250
`define ACK_DELAY_CYCLES ((`ACK_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Number of memory devices
`define NUM_DEVICES 8

`endif

//--- verilog/eeboard_pkg.sv
/*
  Types shared by the memory board control files.
  Assumes nothing beyond the defines header.
*/
package eeboard_pkg;

  // One bus cycle as seen by the board
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] wdata;
    logic mem_rd;
    logic mem_wr;
    logic io_wr;
    logic bhe;
  } bus_req_t;

  // Control sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PULSE,
    ST_DONE
  } seq_state_t;

endpackage

//--- verilog/device_select.sv
/*
  Per-device select decode for the memory array.
  Assumes the address is already known to hit the array window.
*/
`timescale 1ns/100ps
`default_nettype none
`include "eeboard_defines.svh"

module device_select #(
  parameter int NDEV = `NUM_DEVICES
) (
  input wire logic [13:0] offset,
  input wire logic bhe,
  input wire logic wide_bus,
  input wire logic [4:0] density_select_switches,
  output logic [NDEV-1:0] dev_sel
);

  initial begin
    if (NDEV != 8) $error("device_select serves exactly eight devices");
  end

  // Pair index from offset; switch code picks 2K or 4K pair spacing
  function automatic logic [7:0] decode(input logic [13:0] a, input logic b,
                                        input logic w, input logic [4:0] sw);
    logic [1:0] pair;
    logic [7:0] d;
    pair = sw[0] ? a[13:12] : a[12:11];
    d = 8'h00;
    if (w) begin
      d[{pair, 1'b0}] = ~a[0];
      d[{pair, 1'b1}] = b;
    end else begin
      d[{pair, a[0]}] = 1'b1;
    end
    return d;
  endfunction

  // One device for 8-bit, one or both of a pair for 16-bit
  assign dev_sel = decode(offset, bhe, wide_bus, density_select_switches);

endmodule
`default_nettype wire

//--- verilog/pulse_timer.sv
/*
  Write pulse timer: counts the programming pulse from a start strobe.
  Assumes start is a one-cycle pulse and clear aborts the count.
*/
`timescale 1ns/100ps
`default_nettype none
`include "eeboard_defines.svh"

module pulse_timer #(
  parameter int FAST_CYCLES = `WP_FAST_CYCLES,
  parameter int SLOW_CYCLES = `WP_SLOW_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic clear,
  input wire logic slow_type,
  output logic busy,
  output logic done
);

  initial begin
    if (FAST_CYCLES < 1 || SLOW_CYCLES < 1) $error("pulse counts must be positive");
  end

  logic [31:0] count_ff;
  logic busy_ff;

  // Count length follows the installed device type
  always_ff @(posedge clk) begin
    if (reset || clear) begin
      count_ff <= 32'h0;
      busy_ff <= 1'b0;
    end else if (start) begin
      count_ff <= slow_type ? 32'(SLOW_CYCLES - 1) : 32'(FAST_CYCLES - 1);
      busy_ff <= 1'b1;
    end else if (busy_ff) begin
      if (count_ff == 32'h0) busy_ff <= 1'b0;
      else count_ff <= count_ff - 32'h1;
    end
  end

  assign busy = busy_ff;
  assign done = busy_ff && (count_ff == 32'h0);

endmodule
`default_nettype wire

//--- verilog/eeboard_ctrl.sv
/*
  Control logic of a plug-in non-volatile memory board: page decode,
  I/O reset and chip erase decode, write pulse sequencing, completion
  interrupt, and acknowledge timing.
  Assumes bus strobes are synchronous one-cycle-or-longer levels and that
  the array devices themselves sit outside, reached by the select outputs.
*/
// What this block does
// - Respond only within selected 64K page.
// - Four straps give page; open means page zero.
// - Two adjacent I/O addresses trigger control functions.
// - Even address resets; odd enters chip erase.
// - Seven straps match I/O address bits seven..one.
// - Interrupt on write or erase completion.
// - Interrupt on one of eight strap-chosen lines.
// - Interrupt line is pulled low.
// - One memory write latches data, programs autonomously.
// - Device erase by one write, same handling.
// - Reads complete at bus speed, 250 ns.
// - Width strap selects 16-bit, open 8-bit.
// - Pulse 10 ms fast, 50 ms slow.
// - Up to eight devices, 16K bytes.
// - Acknowledge delayed to cover slowest access.
// - Decoder selects one or two devices.
// - Board reset clears interrupt unless a completion lands in the same cycle; accepts new command.
// - Erase-mode I/O data ignored; next write picks device.
// - Completion reported 10 ms (fast) or 50 ms (slow) after write.
`timescale 1ns/100ps
`default_nettype none
`include "eeboard_defines.svh"

module eeboard_ctrl #(
  parameter int FAST_CYCLES = `WP_FAST_CYCLES,
  parameter int SLOW_CYCLES = `WP_SLOW_CYCLES,
  parameter int ACK_CYCLES = `ACK_DELAY_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire eeboard_pkg::bus_req_t bus,
  input wire logic [3:0] page_straps,
  input wire logic [6:0] io_straps,
  input wire logic [7:0] int_line_straps,
  input wire logic bus_width_strap,
  input wire logic slow_device_type,
  input wire logic [4:0] density_select_switches,
  output logic transfer_acknowledge_n,
  output logic [7:0] int_n,
  output logic [7:0] dev_sel,
  output logic write_pulse_width,
  output logic erase_mode,
  output logic [13:0] array_addr,
  output logic [15:0] array_wdata,
  output logic array_oe
);

  initial begin
    if (ACK_CYCLES < 1 || ACK_CYCLES > 255) $error("ACK_CYCLES out of range");
  end

  logic page_hit;
  logic array_hit;
  logic io_hit;
  logic do_reset;
  logic do_erase;
  logic start_write;
  logic timer_busy;
  logic timer_done;
  logic [7:0] sel_now;
  eeboard_pkg::seq_state_t state_ff;
  logic erase_ff;
  logic irq_ff;
  logic [13:0] addr_ff;
  logic [15:0] data_ff;
  logic [7:0] sel_ff;
  logic [7:0] ack_cnt_ff;
  logic ack_ff;
  logic oe_ff;
  logic cycle_active;

  // Page match: open straps read as zero, giving the lowest page
  assign page_hit = (bus.addr[`PAGE_MSB:`PAGE_LSB] == page_straps);
  // Only the low 16K of the page holds devices
  assign array_hit = page_hit && (bus.addr[`ARRAY_TOP_MSB:`ARRAY_TOP_LSB] == 2'b00);

  // I/O decode: installed strap wants one, open wants zero
  assign io_hit = bus.io_wr && (bus.addr[`IO_MATCH_MSB:`IO_MATCH_LSB] == io_straps);
  assign do_reset = io_hit && !bus.addr[`IO_FUNC_BIT];
  assign do_erase = io_hit && bus.addr[`IO_FUNC_BIT];

  // A write is accepted only when idle; while programming it is dropped
  assign start_write = array_hit && bus.mem_wr && (state_ff == eeboard_pkg::ST_IDLE);

  device_select #(
    .NDEV(8)
  ) u_sel (
    .offset(bus.addr[13:0]),
    .bhe(bus.bhe),
    .wide_bus(bus_width_strap),
    .density_select_switches(density_select_switches),
    .dev_sel(sel_now)
  );

  pulse_timer #(
    .FAST_CYCLES(FAST_CYCLES),
    .SLOW_CYCLES(SLOW_CYCLES)
  ) u_timer (
    .clk(clk),
    .reset(reset),
    .start(start_write),
    .clear(do_reset),
    .slow_type(slow_device_type),
    .busy(timer_busy),
    .done(timer_done)
  );

  // Sequencer: idle, pulse running, done with interrupt pending
  always_ff @(posedge clk) begin
    if (reset || do_reset) begin
      state_ff <= eeboard_pkg::ST_IDLE;
    end else begin
      case (state_ff)
        eeboard_pkg::ST_IDLE: begin
          if (start_write) state_ff <= eeboard_pkg::ST_PULSE;
        end
        eeboard_pkg::ST_PULSE: begin
          if (timer_done) state_ff <= eeboard_pkg::ST_DONE;
        end
        eeboard_pkg::ST_DONE: begin
          state_ff <= eeboard_pkg::ST_DONE; // Waits for board reset
        end
        default: begin
          state_ff <= eeboard_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Erase mode: set by odd I/O write while idle, its data ignored; only reset clears
  always_ff @(posedge clk) begin
    if (reset || do_reset) begin
      erase_ff <= 1'b0;
    end else if (do_erase && state_ff == eeboard_pkg::ST_IDLE) begin
      erase_ff <= 1'b1;
    end
  end

  // Completion interrupt; set wins over a board reset in the same cycle, only hard reset beats it
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_ff <= 1'b0;
    end else if (timer_done && state_ff == eeboard_pkg::ST_PULSE) begin
      irq_ff <= 1'b1;
    end else if (do_reset) begin
      irq_ff <= 1'b0;
    end
  end

  // Latch address, data and device select from the single write cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_ff <= 14'h0000;
      data_ff <= 16'h0000;
      sel_ff <= 8'h00;
    end else if (start_write) begin
      addr_ff <= bus.addr[13:0];
      // Erase drives all ones so the chosen device clears fully
      data_ff <= erase_ff ? 16'hFFFF : bus.wdata;
      sel_ff <= sel_now;
    end
  end

  // Read enable follows a read cycle hitting the array, except while a write pulse runs
  always_ff @(posedge clk) begin
    if (reset) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= array_hit && bus.mem_rd && (state_ff != eeboard_pkg::ST_PULSE);
    end
  end

  assign cycle_active = array_hit && (bus.mem_rd || bus.mem_wr);

  // Acknowledge counter: a fixed delay covers the slowest access time;
  // cycles during a pulse still ack so the host bus never hangs
  always_ff @(posedge clk) begin
    if (reset || !cycle_active) begin
      ack_cnt_ff <= 8'h00;
      ack_ff <= 1'b0;
    end else if (ack_cnt_ff == 8'(ACK_CYCLES - 1)) begin
      ack_ff <= 1'b1;
    end else begin
      ack_cnt_ff <= ack_cnt_ff + 8'h01;
    end
  end

  // I/O writes to the board's two strapped addresses are acknowledged too, after one cycle
  logic io_ack_ff;
  always_ff @(posedge clk) begin
    if (reset) io_ack_ff <= 1'b0;
    else io_ack_ff <= io_hit;
  end

  assign transfer_acknowledge_n = ~((ack_ff && cycle_active) || (io_ack_ff && bus.io_wr));

  // Interrupt onto the strap-chosen line, active low
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      int_n[i] = ~(irq_ff && int_line_straps[i]);
    end
  end

  assign dev_sel = (state_ff == eeboard_pkg::ST_PULSE) ? sel_ff : (oe_ff ? sel_now : 8'h00);
  assign write_pulse_width = timer_busy && (state_ff == eeboard_pkg::ST_PULSE);
  assign erase_mode = erase_ff;
  assign array_addr = addr_ff;
  assign array_wdata = data_ff;
  assign array_oe = oe_ff;

endmodule
`default_nettype wire

//--- verif/eeboard_ctrl_checker.sv
/*
  Concurrent checks on the board control ports.
  Assumes one clock, synchronous reset and straps that change only while idle.
*/
`timescale 1ns/100ps
`default_nettype none
module eeboard_ctrl_checker #(
  parameter int FAST_CYCLES = 20,
  parameter int SLOW_CYCLES = 40
) (
  input wire logic clk,
  input wire logic reset,
  input wire eeboard_pkg::bus_req_t bus,
  input wire logic [3:0] page_straps,
  input wire logic [6:0] io_straps,
  input wire logic [7:0] int_line_straps,
  input wire logic slow_device_type,
  input wire logic transfer_acknowledge_n,
  input wire logic [7:0] int_n,
  input wire logic write_pulse_width,
  input wire logic erase_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [31:0] hi_cnt_ff;
  logic page_hit;
  logic io_hit;
  logic idle;
  // Decodes the checks share
  assign page_hit = bus.addr[19:16] == page_straps && bus.addr[15:14] == 2'h0;
  assign io_hit = bus.io_wr && bus.addr[7:1] == io_straps;
  assign idle = !write_pulse_width && int_n == 8'hFF;
  // Pulse length in cycles; a repetition cannot hold counts this long
  always_ff @(posedge clk) begin
    if (reset || !write_pulse_width) begin
      hi_cnt_ff <= 32'h0;
    end else begin
      hi_cnt_ff <= hi_cnt_ff + 32'h1;
    end
  end
  a_off_page_quiet: assert property (bus.mem_rd && bus.addr[19:16] != page_straps
    |-> transfer_acknowledge_n) else $error("ack outside the page");
  a_ack_wait_len: assert property ($rose(bus.mem_rd) && page_hit
    |-> transfer_acknowledge_n[*8] ##[1:8] !transfer_acknowledge_n) else $error("ack timing");
  a_io_reset_clears: assert property (io_hit && !bus.addr[0]
    |=> int_n == 8'hFF && !erase_mode && !write_pulse_width) else $error("reset left state");
  a_erase_enter: assert property (io_hit && bus.addr[0] && idle
    |=> erase_mode) else $error("erase mode not entered");
  a_io_foreign: assert property (bus.io_wr && bus.addr[7:1] != io_straps && !erase_mode
    |=> !erase_mode) else $error("foreign io address acted on");
  a_int_strapped: assert property (&(int_n | int_line_straps))
    else $error("interrupt on unselected line");
  a_write_start: assert property (bus.mem_wr && page_hit && idle
    |-> ##[1:2] write_pulse_width) else $error("write pulse not started");
  a_pulse_len: assert property ($fell(write_pulse_width) && !$past(bus.io_wr)
    |-> hi_cnt_ff >= (slow_device_type ? SLOW_CYCLES : FAST_CYCLES)
    && hi_cnt_ff <= (slow_device_type ? SLOW_CYCLES : FAST_CYCLES) + 1) else $error("pulse width");
  a_done_irq: assert property ($fell(write_pulse_width) && !$past(bus.io_wr)
    |-> ##[0:2] int_n != 8'hFF) else $error("no completion interrupt");
endmodule
bind eeboard_ctrl eeboard_ctrl_checker #(.FAST_CYCLES(FAST_CYCLES), .SLOW_CYCLES(SLOW_CYCLES)) u_chk (
  .clk(clk), .reset(reset), .bus(bus), .page_straps(page_straps), .io_straps(io_straps),
  .int_line_straps(int_line_straps), .slow_device_type(slow_device_type),
  .transfer_acknowledge_n(transfer_acknowledge_n), .int_n(int_n),
  .write_pulse_width(write_pulse_width), .erase_mode(erase_mode));
`default_nettype wire

//--- verif/host_model.sv
/*
  Host processor on the system bus: runs one memory or I/O cycle per call.
  Assumes the board answers with an active-low acknowledge.
*/
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic clk,
  input wire logic transfer_acknowledge_n,
  output var eeboard_pkg::bus_req_t bus
);
  initial bus = '0;
  // One whole cycle, held until acknowledged or 30 cycles pass; released lines show inverted data
  task automatic cycle(input logic [19:0] a, input logic [15:0] d, input logic [2:0] k,
                       output logic acked, output int lat);
    acked = 1'b0;
    lat = 0;
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.bhe <= 1'b1;
    {bus.mem_rd, bus.mem_wr, bus.io_wr} <= k;
    while (!acked && lat < 30) begin
      @(posedge clk);
      lat++;
      acked = (transfer_acknowledge_n === 1'b0);
    end
    {bus.mem_rd, bus.mem_wr, bus.io_wr} <= 3'h0;
    bus.wdata <= ~d;
  endtask
endmodule
`default_nettype wire

//--- verif/eeboard_ctrl_tb.sv
/*
  Self-checking bench for the board control logic.
  Assumes shortened pulse counts; the host model drives the bus.
*/
`timescale 1ns/100ps
`default_nettype none
module eeboard_ctrl_tb;
  localparam int FAST = 20;
  localparam int SLOW = 40;
  logic clk = 1'b0;
  logic reset = 1'b1;
  eeboard_pkg::bus_req_t bus;
  logic [3:0] page_straps = 4'h5;
  logic [6:0] io_straps = 7'h45;
  logic [7:0] int_line_straps = 8'h01;
  logic slow_device_type = 1'b0;
  logic ack_n, wpw, erase_mode, acked;
  logic [7:0] int_n, sel, dev_sel_w;
  logic oe_w;
  logic [13:0] array_addr;
  logic [15:0] array_wdata;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int lat, n;
  always #10 clk = ~clk;
  host_model u_host (.clk(clk), .transfer_acknowledge_n(ack_n), .bus(bus));
  eeboard_ctrl #(.FAST_CYCLES(FAST), .SLOW_CYCLES(SLOW)) u_dut (.clk(clk), .reset(reset),
    .bus(bus), .page_straps(page_straps), .io_straps(io_straps),
    .int_line_straps(int_line_straps), .bus_width_strap(1'b1),
    .slow_device_type(slow_device_type), .density_select_switches(5'h00),
    .transfer_acknowledge_n(ack_n), .int_n(int_n), .dev_sel(dev_sel_w), .write_pulse_width(wpw),
    .erase_mode(erase_mode), .array_addr(array_addr), .array_wdata(array_wdata),
    .array_oe(oe_w));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("mismatches=%0d comparisons=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task io(input logic [7:0] a);
    u_host.cycle({12'h000, a}, 16'h00C3, 3'h1, acked, lat);
  endtask
  task mem(input logic [19:0] a, input logic [15:0] d, input logic [2:0] k);
    u_host.cycle(a, d, k, acked, lat);
  endtask
  // Bounded wait for any interrupt line to drop
  task wait_irq;
    n = 0;
    while (int_n === 8'hFF && n < 200) begin
      @(posedge clk);
      n++;
    end
  endtask
  // Hang guard, far above the expected run of about 500 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    io(8'h8A);
    check({int_n, erase_mode}, 9'h1FE);
    mem(20'h40010, 16'h0000, 3'h4);
    check(acked, 1'b0);
    mem(20'h50010, 16'h0000, 3'h4);
    check(acked && lat > 13 && lat < 17, 1'b1);
    // Even offset, high byte enabled, 16-bit: both devices of pair zero
    check({oe_w, dev_sel_w}, 9'h103);
    page_straps <= 4'h0;
    mem(20'h00010, 16'h0000, 3'h4);
    check(acked, 1'b1);
    page_straps <= 4'h5;
    // Every interrupt line; a second write while done must be ignored
    for (int i = 0; i < 8; i++) begin
      sel = 8'h01 << i;
      int_line_straps <= sel;
      mem(20'h50020 + 20'(i), 16'hA550 + 16'(i), 3'h2);
      check(array_addr, 14'h0020 + 14'(i));
      wait_irq;
      check(int_n ^ sel, 8'hFF);
      mem(20'h50030, 16'h1234, 3'h2);
      check(array_wdata, 16'hA550 + 16'(i));
      io(8'h8A);
      check(int_n, 8'hFF);
    end
    slow_device_type <= 1'b1;
    mem(20'h50040, 16'h0F0F, 3'h2);
    wait_irq;
    check(n > FAST && n <= SLOW, 1'b1);
    io(8'h8A);
    slow_device_type <= 1'b0;
    io(8'h8B);
    check(erase_mode, 1'b1);
    mem(20'h50100, 16'h1234, 3'h2);
    check(array_wdata, 16'hFFFF);
    wait_irq;
    check(int_n, 8'h7F);
    io(8'h8A);
    check(erase_mode, 1'b0);
    io(8'h8D);
    check(erase_mode, 1'b0);
    mem(20'h50050, 16'h5555, 3'h2);
    io(8'h8A);
    check({wpw, int_n}, 9'h0FF);
    end_of_test();
  end
endmodule
`default_nettype wire
